// ===== rtl/scmw_pkg.sv
/*
  Constants shared by the serial code memory writer: serial command codes,
  core instruction encodings, register offsets and field positions.
  Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
*/
package scmw_pkg;

  // ****************************************************************
  // Serial framing
  // ****************************************************************
  localparam int         CMD_W          = 4;
  localparam int         PAY_W          = 16;
  localparam int         FRAME_W        = CMD_W + PAY_W;
  localparam int         ENTRY_W        = FRAME_W + 1;
  localparam int         HOLD_CLOCK_IDX = 3;
  localparam logic [3:0] CMD_CORE       = 4'h0;
  localparam logic [3:0] CMD_LOAD_INC   = 4'hD;
  localparam logic [3:0] CMD_LOAD_START = 4'hF;

  // ****************************************************************
  // Core instructions and file addresses
  // ****************************************************************
  localparam logic [7:0] OP_LIT       = 8'h0E;
  localparam logic [7:0] OP_STORE     = 8'h6E;
  localparam logic [7:0] OP_CLEAR     = 8'h6A;
  localparam logic [3:0] OP_BSET      = 4'h8;
  localparam logic [3:0] OP_BCLR      = 4'h9;
  localparam logic [7:0] F_PTR_U      = 8'hF8;
  localparam logic [7:0] F_PTR_H      = 8'hF7;
  localparam logic [7:0] F_PTR_L      = 8'hF6;
  localparam logic [7:0] F_MEMCTL     = 8'hA6;
  localparam int         CODE_SEL_BIT = 7;
  localparam int         CFG_SEL_BIT  = 6;
  localparam int         PTR_W        = 22;
  localparam int         ERASE_BYTES  = 64;
  localparam logic [15:0] MEM_ERASED  = 16'hFFFF;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_PTR     = 8'h08;
  localparam logic [7:0] ADDR_MEMCTL  = 8'h0C;
  localparam logic [7:0] ADDR_SIZES   = 8'h10;
  localparam logic [7:0] ADDR_RD_ADDR = 8'h14;
  localparam logic [7:0] ADDR_RD_DATA = 8'h18;
  localparam logic [7:0] ADDR_COMMITS = 8'h1C;
  localparam int         CTRL_EN_BIT  = 0;
  localparam logic       CTRL_EN_RST  = 1'b1;
  localparam int         ST_OVF_BIT   = 3;
  localparam int         ST_REF_BIT   = 4;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  typedef enum logic {EX_IDLE, EX_COMMIT} scmw_exec_type;

endpackage

// ===== rtl/scmw_stream_if.sv
/*
  Valid/ready stream between the serial front end and its frame FIFO.
  Assumes both sides run on the same clock.
*/
`timescale 1ns/100ps
interface scmw_stream_if #(parameter int WIDTH = 21) ();
  logic             push_valid;
  logic             push_ready;
  logic [WIDTH-1:0] push_data;
  logic             pop_valid;
  logic             pop_ready;
  logic [WIDTH-1:0] pop_data;

  modport user (output push_valid, push_data, pop_ready,
                input  push_ready, pop_valid, pop_data);
  modport fifo (input  push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
endinterface

// ===== rtl/scmw_fifo.sv
/*
  Frame FIFO with show-ahead output and honest full and empty.
  Assumes a synchronous active-low reset on the same clock as both sides.
*/
`timescale 1ns/100ps
module scmw_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  scmw_stream_if.fifo port
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("FIFO depth must be a power of two of at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr_ptr;
    logic [AW:0]                 rd_ptr;
  } scmw_fifo_state_type;

  scmw_fifo_state_type s_reg;
  scmw_fifo_state_type s_next;
  logic                full;
  logic                empty;

  assign empty = (s_reg.wr_ptr == s_reg.rd_ptr);
  assign full  = (s_reg.wr_ptr[AW] != s_reg.rd_ptr[AW]) &&
                 (s_reg.wr_ptr[AW-1:0] == s_reg.rd_ptr[AW-1:0]);
  assign port.push_ready = !full;
  assign port.pop_valid  = !empty;
  assign port.pop_data   = s_reg.mem[s_reg.rd_ptr[AW-1:0]];

  always_comb begin
    s_next = s_reg;
    if (port.push_valid && !full) begin
      s_next.mem[s_reg.wr_ptr[AW-1:0]] = port.push_data;
      s_next.wr_ptr = s_reg.wr_ptr + 1'b1;
    end
    if (port.pop_ready && !empty) begin
      s_next.rd_ptr = s_reg.rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ===== rtl/scmw_mem.sv
/*
  Small memory with one write port and one registered read port.
  Assumes a synchronous active-low reset; contents reset to INIT.
*/
`timescale 1ns/100ps
module scmw_mem #(
  parameter int              WIDTH = 16,
  parameter int              DEPTH = 32,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [WIDTH-1:0]         wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output      logic [WIDTH-1:0]         rdata
);
  if (DEPTH < 2) begin : g_bad_depth
    $error("Memory depth must be at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0]            rdata;
  } scmw_mem_state_type;

  scmw_mem_state_type s_reg;
  scmw_mem_state_type s_next;

  assign rdata = s_reg.rdata;

  always_comb begin
    s_next       = s_reg;
    s_next.rdata = s_reg.mem[raddr];
    if (we) begin
      s_next.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= {(DEPTH + 1){INIT}};
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ===== rtl/scmw_top.sv
/*
  Serial code memory writer: two-wire serial port front end, core
  instruction subset, write buffer, commit engine, code memory and an
  AXI4-Lite register slave.
  Assumes the serial clock and data pins are asynchronous to aclk and
  that the serial clock is much slower than aclk.
*/
`timescale 1ns/100ps

// Summary of operation
// - Buffers map onto size-aligned regions from zero.
// - Commit copies buffer into region holding pointer.
// - Start command 1111; duration timed by serial clock.
// - Programming ends on falling serial clock.
// - Write buffer is 8, 16, 32 or 64 bytes.
// - Erase buffer is always 64 bytes.
// - Command 1101 stores word, pointer plus two.
// - Command 1111 stores last word, then commits.
module scmw_top
  import scmw_pkg::*;
#(
  parameter int WBUF_BYTES = 32,
  parameter int CODE_WORDS = 512,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        prog_serial_clock,
  input  wire logic        prog_serial_data_in,
  output      logic        prog_serial_data_out,
  output      logic        prog_serial_data_oe_n,
  output      logic        programming_active
);
  localparam int WBUF_WORDS = WBUF_BYTES / 2;
  localparam int BUF_AW     = $clog2(WBUF_WORDS);
  localparam int CODE_AW    = $clog2(CODE_WORDS);

  if (WBUF_BYTES != 8 && WBUF_BYTES != 16 &&
      WBUF_BYTES != 32 && WBUF_BYTES != 64) begin : g_bad_wbuf
    $error("Write buffer must be 8, 16, 32 or 64 bytes");
  end
  if ((CODE_WORDS & (CODE_WORDS - 1)) != 0 || CODE_WORDS < ERASE_BYTES / 2 ||
      CODE_AW > PTR_W - 1) begin : g_bad_code
    $error("Code memory words must be a power of two within pointer reach");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic                clk_s1;
    logic                clk_s2;
    logic                clk_s3;
    logic                dat_s1;
    logic                dat_s2;
    logic [FRAME_W-1:0]  shift;
    logic [4:0]          bit_cnt;
    logic                armed;
    logic                hv_active;
    logic                frame_pend;
    logic [FRAME_W-1:0]  frame_data;
    logic                mark_pend;
    logic                mark_first;
    logic                enable;
    logic                overflow;
    logic                refused;
    scmw_exec_type       ex_state;
    logic [7:0]          work;
    logic [PTR_W-1:0]    ptr;
    logic [7:0]          memctl;
    logic [BUF_AW:0]     cidx;
    logic [CODE_AW-1:0]  cbase;
    logic [15:0]         commits;
    logic [CODE_AW-1:0]  rd_addr;
    logic                aw_got;
    logic [7:0]          awaddr;
    logic                w_got;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
    logic                data_out;
    logic                data_oe_n;
  } scmw_state_type;

  scmw_state_type     s_reg;
  scmw_state_type     s_next;
  logic               buf_we;
  logic [BUF_AW-1:0]  buf_waddr;
  logic [PAY_W-1:0]   buf_wdata;
  logic [BUF_AW-1:0]  buf_raddr;
  logic [PAY_W-1:0]   buf_rdata;
  logic               code_we;
  logic [CODE_AW-1:0] code_waddr;
  logic [PAY_W-1:0]   code_wdata;
  logic [PAY_W-1:0]   code_rdata;
  logic               push_mark;

  scmw_stream_if #(.WIDTH(ENTRY_W)) frames ();

  scmw_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk    (aclk),
    .aresetn (aresetn),
    .port    (frames)
  );

  scmw_mem #(.WIDTH(PAY_W), .DEPTH(WBUF_WORDS), .INIT(MEM_ERASED)) u_wbuf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (buf_we),
    .waddr   (buf_waddr),
    .wdata   (buf_wdata),
    .raddr   (buf_raddr),
    .rdata   (buf_rdata)
  );

  scmw_mem #(.WIDTH(PAY_W), .DEPTH(CODE_WORDS), .INIT(MEM_ERASED)) u_code (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (code_we),
    .waddr   (code_waddr),
    .wdata   (code_wdata),
    .raddr   (s_reg.rd_addr),
    .rdata   (code_rdata)
  );

  // The marker that asks for a commit is queued behind every older frame.
  assign push_mark          = s_reg.mark_pend && (!s_reg.frame_pend || s_reg.mark_first);
  assign frames.push_valid  = s_reg.frame_pend || s_reg.mark_pend;
  assign frames.push_data   = push_mark ? {1'b1, {FRAME_W{1'b0}}} : {1'b0, s_reg.frame_data};
  assign frames.pop_ready   = (s_reg.ex_state == EX_IDLE);

  assign s_axi_awready         = s_reg.awready;
  assign s_axi_wready          = s_reg.wready;
  assign s_axi_bvalid          = s_reg.bvalid;
  assign s_axi_bresp           = s_reg.bresp;
  assign s_axi_arready         = s_reg.arready;
  assign s_axi_rvalid          = s_reg.rvalid;
  assign s_axi_rresp           = s_reg.rresp;
  assign s_axi_rdata           = s_reg.rdata;
  assign prog_serial_data_out  = s_reg.data_out;
  assign prog_serial_data_oe_n = s_reg.data_oe_n;
  assign programming_active    = s_reg.hv_active;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  always_comb begin
    logic               rise;
    logic               fall;
    logic [FRAME_W-1:0] fr;
    logic [FRAME_W-1:0] ent;
    logic [7:0]         val;
    logic [31:0]        wv;
    logic [31:0]        st_view;
    rise       = s_reg.clk_s2 && !s_reg.clk_s3;
    fall       = !s_reg.clk_s2 && s_reg.clk_s3;
    fr         = {s_reg.dat_s2, s_reg.shift[FRAME_W-1:1]};
    ent        = frames.pop_data[FRAME_W-1:0];
    val        = 8'h00;
    wv         = 32'h0;
    st_view    = 32'({s_reg.refused, s_reg.overflow, (s_reg.ex_state == EX_COMMIT),
                      s_reg.armed, s_reg.hv_active});
    s_next     = s_reg;
    buf_we     = 1'b0;
    buf_waddr  = s_reg.ptr[BUF_AW:1];
    buf_wdata  = ent[FRAME_W-1:CMD_W];
    buf_raddr  = s_reg.cidx[BUF_AW-1:0];
    code_we    = 1'b0;
    code_waddr = s_reg.cbase + CODE_AW'(s_reg.cidx - 1'b1);
    code_wdata = buf_rdata;

    // ****************************************************************
    // Register bus
    // ****************************************************************
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.aw_got = 1'b1;
      s_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.w_got = 1'b1;
      s_next.wdata = s_axi_wdata;
      s_next.wstrb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = RESP_OKAY;
      case (s_reg.awaddr)
        ADDR_CTRL: begin
          wv = merge(32'(s_reg.enable), s_reg.wdata, s_reg.wstrb);
          s_next.enable = wv[CTRL_EN_BIT];
        end
        ADDR_STATUS: begin
          wv = merge(32'h0, s_reg.wdata, s_reg.wstrb);
          s_next.overflow = s_reg.overflow && !wv[ST_OVF_BIT];
          s_next.refused  = s_reg.refused && !wv[ST_REF_BIT];
        end
        ADDR_RD_ADDR: begin
          wv = merge(32'(s_reg.rd_addr), s_reg.wdata, s_reg.wstrb);
          s_next.rd_addr = wv[CODE_AW-1:0];
        end
        ADDR_PTR, ADDR_MEMCTL, ADDR_SIZES, ADDR_RD_DATA, ADDR_COMMITS: begin
        end
        default: begin
          s_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_reg.rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CTRL:    s_next.rdata = 32'(s_reg.enable);
        ADDR_STATUS:  s_next.rdata = st_view;
        ADDR_PTR:     s_next.rdata = 32'(s_reg.ptr);
        ADDR_MEMCTL:  s_next.rdata = 32'(s_reg.memctl);
        ADDR_SIZES:   s_next.rdata = 32'({8'(ERASE_BYTES), 8'(WBUF_BYTES)});
        ADDR_RD_ADDR: s_next.rdata = 32'(s_reg.rd_addr);
        ADDR_RD_DATA: s_next.rdata = 32'(code_rdata);
        ADDR_COMMITS: s_next.rdata = 32'(s_reg.commits);
        default: begin
          s_next.rdata = 32'h0;
          s_next.rresp = RESP_SLVERR;
        end
      endcase
    end

    // ****************************************************************
    // Serial front end
    // ****************************************************************
    s_next.clk_s1 = prog_serial_clock;
    s_next.clk_s2 = s_reg.clk_s1;
    s_next.clk_s3 = s_reg.clk_s2;
    s_next.dat_s1 = prog_serial_data_in;
    s_next.dat_s2 = s_reg.dat_s1;
    if (frames.push_valid && frames.push_ready) begin
      if (push_mark) begin
        s_next.mark_pend  = 1'b0;
        s_next.mark_first = 1'b0;
      end else begin
        s_next.frame_pend = 1'b0;
      end
    end
    if (!s_reg.enable) begin
      s_next.bit_cnt   = 5'h00;
      s_next.armed     = 1'b0;
      s_next.hv_active = 1'b0;
    end else if (rise) begin
      s_next.shift = fr;
      if (s_reg.armed && s_reg.bit_cnt == 5'(HOLD_CLOCK_IDX)) begin
        s_next.hv_active = 1'b1;
        s_next.armed     = 1'b0;
      end
      if (s_reg.bit_cnt == 5'(FRAME_W - 1)) begin
        s_next.bit_cnt = 5'h00;
        if (s_next.frame_pend) begin
          s_next.overflow = 1'b1;
        end else begin
          s_next.frame_pend = 1'b1;
          s_next.frame_data = fr;
          s_next.mark_first = s_next.mark_pend;
        end
        if (fr[CMD_W-1:0] == CMD_LOAD_START) begin
          s_next.armed = 1'b1;
        end
      end else begin
        s_next.bit_cnt = s_reg.bit_cnt + 1'b1;
      end
    end else if (fall && s_reg.hv_active) begin
      s_next.hv_active = 1'b0;
      if (s_next.mark_pend) begin
        s_next.overflow = 1'b1;
      end else begin
        s_next.mark_pend = 1'b1;
      end
    end

    // ****************************************************************
    // Frame execution and commit
    // ****************************************************************
    unique case (s_reg.ex_state)
      EX_IDLE: begin
        if (frames.pop_valid) begin
          if (frames.pop_data[FRAME_W]) begin
            s_next.ex_state = EX_COMMIT;
            s_next.cidx     = '0;
            s_next.cbase    = {s_reg.ptr[CODE_AW:BUF_AW+1], {BUF_AW{1'b0}}};
          end else if (ent[CMD_W-1:0] == CMD_CORE) begin
            if (ent[FRAME_W-1:FRAME_W-8] == OP_LIT) begin
              s_next.work = ent[CMD_W+7:CMD_W];
            end else if (ent[FRAME_W-1:FRAME_W-8] == OP_STORE ||
                         ent[FRAME_W-1:FRAME_W-8] == OP_CLEAR) begin
              val = (ent[FRAME_W-1:FRAME_W-8] == OP_STORE) ? s_reg.work : 8'h00;
              case (ent[CMD_W+7:CMD_W])
                F_PTR_U:  s_next.ptr[PTR_W-1:16] = val[PTR_W-17:0];
                F_PTR_H:  s_next.ptr[15:8]       = val;
                F_PTR_L:  s_next.ptr[7:0]        = val;
                F_MEMCTL: s_next.memctl          = val;
                default: begin
                end
              endcase
            end else if ((ent[FRAME_W-1:FRAME_W-4] == OP_BSET ||
                          ent[FRAME_W-1:FRAME_W-4] == OP_BCLR) &&
                         ent[CMD_W+7:CMD_W] == F_MEMCTL) begin
              s_next.memctl[ent[CMD_W+11:CMD_W+9]] =
                (ent[FRAME_W-1:FRAME_W-4] == OP_BSET);
            end
          end else if (ent[CMD_W-1:0] == CMD_LOAD_INC ||
                       ent[CMD_W-1:0] == CMD_LOAD_START) begin
            if (s_reg.memctl[CODE_SEL_BIT] && !s_reg.memctl[CFG_SEL_BIT]) begin
              buf_we = 1'b1;
            end else begin
              s_next.refused = 1'b1;
            end
            if (ent[CMD_W-1:0] == CMD_LOAD_INC) begin
              s_next.ptr = s_reg.ptr + PTR_W'(2);
            end
          end
        end
      end
      EX_COMMIT: begin
        code_we       = (s_reg.cidx != '0);
        s_next.cidx   = s_reg.cidx + 1'b1;
        if (s_reg.cidx == (BUF_AW + 1)'(WBUF_WORDS)) begin
          s_next.ex_state = EX_IDLE;
          s_next.commits  = s_reg.commits + 1'b1;
        end
      end
    endcase

    s_next.awready = !s_next.aw_got && !s_next.bvalid;
    s_next.wready  = !s_next.w_got && !s_next.bvalid;
    s_next.arready = !s_next.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg           <= '0;
      s_reg.enable    <= CTRL_EN_RST;
      s_reg.data_oe_n <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// ===== verif/scmw_top_monitor.sv
/* Port checker for the serial code memory writer.
   Assumes it is bound to scmw_top with the same buffer size. */
`timescale 1ns/100ps
module scmw_top_monitor
  import scmw_pkg::*;
#(
  parameter int WBUF_BYTES = 32
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        prog_serial_clock,
  input wire logic        prog_serial_data_out,
  input wire logic        prog_serial_data_oe_n,
  input wire logic        programming_active
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_fall;
    prog_serial_clock ##1 !prog_serial_clock;
  endsequence
  sequence s_ar(a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  chk_data_released: assert property (prog_serial_data_oe_n && !prog_serial_data_out)
    else $error("data pin driven");
  chk_start_clock_high: assert property ($rose(programming_active) |-> prog_serial_clock)
    else $error("programming began with clock low");
  chk_hold_keeps: assert property (programming_active && prog_serial_clock |=> programming_active)
    else $error("programming ended while clock high");
  chk_end_on_fall: assert property (s_fall |-> ##[1:6] !programming_active)
    else $error("programming not ended after clock fall");
  chk_low_idle: assert property (!prog_serial_clock [*6] |-> !programming_active)
    else $error("programming active with clock low");
  chk_wbuf_size: assert property (s_ar(ADDR_SIZES) |=> s_axi_rdata[7:0] == 8'(WBUF_BYTES))
    else $error("write buffer size wrong");
  chk_ebuf_size: assert property (s_ar(ADDR_SIZES) |=> s_axi_rdata[15:8] == 8'(ERASE_BYTES))
    else $error("erase buffer size wrong");
  chk_ptr_width: assert property (s_ar(ADDR_PTR) |=> s_axi_rdata[31:22] == 10'h000)
    else $error("pointer wider than 22 bits");
endmodule
bind scmw_top scmw_top_monitor #(.WBUF_BYTES(WBUF_BYTES)) mon (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .prog_serial_clock(prog_serial_clock),
  .prog_serial_data_out(prog_serial_data_out), .prog_serial_data_oe_n(prog_serial_data_oe_n),
  .programming_active(programming_active));

// ===== verif/scmw_prog_model.sv
/* Serial programmer model: sends 4-bit command plus 16-bit payload frames.
   Assumes the caller enters send just after a rising aclk edge. */
`timescale 1ns/100ps
module scmw_prog_model
  import scmw_pkg::*;
#(
  parameter int PROGRAMMING_HOLD_TIME = 40,
  parameter int ARRAY_DISCHARGE_TIME  = 20
) (
  input  wire logic aclk,
  output      logic prog_serial_clock,
  output      logic prog_serial_data
);
  initial begin
    prog_serial_clock = 1'b0;
    prog_serial_data  = 1'b0;
  end
  // The clock stands low between frames; data shows the inverse when idle.
  task automatic send(input logic [3:0] cmd, input logic [15:0] pay, input bit hold);
    logic [19:0] f;
    bit          h;
    f = {pay, cmd};
    for (int k = 0; k < FRAME_W; k++) begin
      h = hold && k == HOLD_CLOCK_IDX;
      prog_serial_data <= f[k];
      repeat (2) @(posedge aclk);
      prog_serial_clock <= 1'b1;
      repeat (h ? PROGRAMMING_HOLD_TIME : 5) @(posedge aclk);
      prog_serial_clock <= 1'b0;
      repeat (h ? ARRAY_DISCHARGE_TIME : 3) @(posedge aclk);
    end
    prog_serial_data <= ~f[19];
    @(posedge aclk);
  endtask
endmodule

// ===== verif/scmw_top_tb.sv
/* Testbench for scmw_top: AXI4-Lite master tasks and serial frames.
   Assumes an 8-byte write buffer and 64-word code memory. */
`timescale 1ns/100ps
module scmw_top_tb
  import scmw_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, sclk, sdat, active;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  pb [3] = '{8'h00, 8'h00, 8'h08};
  logic [7:0]  pf [3] = '{F_PTR_U, F_PTR_H, F_PTR_L};
  int          num_errors, total_checks;
  scmw_top #(.WBUF_BYTES(8), .CODE_WORDS(64)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .prog_serial_clock(sclk), .prog_serial_data_in(sdat), .prog_serial_data_out(),
    .prog_serial_data_oe_n(), .programming_active(active));
  scmw_prog_model prog (.aclk(aclk), .prog_serial_clock(sclk), .prog_serial_data(sdat));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] e);
    bit aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    e = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    e = rresp;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 48'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(ADDR_SIZES, d, r);
    check(d, 32'h0000_4008);
    rd(8'h20, d, r);
    check({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    prog.send(CMD_CORE, 16'h8EA6, 0);
    prog.send(CMD_CORE, 16'h9CA6, 0);
    rd(ADDR_MEMCTL, d, r);
    check(d, 32'h0000_0080);
    for (int i = 0; i < 3; i++) begin
      prog.send(CMD_CORE, {OP_LIT, pb[i]}, 0);
      prog.send(CMD_CORE, {OP_STORE, pf[i]}, 0);
    end
    rd(ADDR_PTR, d, r);
    check(d, 32'h0000_0008);
    for (int i = 0; i < 3; i++) prog.send(CMD_LOAD_INC, 16'hA001 + 16'(i), 0);
    rd(ADDR_PTR, d, r);
    check(d, 32'h0000_000E);
    prog.send(CMD_LOAD_START, 16'hA004, 0);
    check({31'h0, active}, 32'h0);
    fork
      prog.send(CMD_CORE, 16'h0000, 1);
      begin
        repeat (55) @(posedge aclk);
        check({31'h0, active}, 32'h1);
      end
    join
    d = 32'h0;
    for (int n = 0; n < 40 && d !== 32'h1; n++) rd(ADDR_COMMITS, d, r);
    check(d, 32'h1);
    rd(ADDR_STATUS, d, r);
    check(d, 32'h0);
    for (int w = 3; w < 9; w++) begin
      wr(ADDR_RD_ADDR, 32'(w), r);
      rd(ADDR_RD_DATA, d, r);
      check(d, (w > 3 && w < 8) ? 32'hA001 + 32'(w - 4) : 32'(MEM_ERASED));
    end
    prog.send(CMD_CORE, {OP_LIT, 8'h10}, 0);
    prog.send(CMD_CORE, {OP_STORE, F_PTR_L}, 0);
    prog.send(CMD_LOAD_START, 16'hA005, 0);
    prog.send(CMD_CORE, 16'h0000, 1);
    wr(ADDR_RD_ADDR, 32'h8, r);
    check(32'(r), 32'(RESP_OKAY));
    rd(ADDR_RD_DATA, d, r);
    check(d, 32'hA005);
    rd(ADDR_COMMITS, d, r);
    check(d, 32'h2);
    prog.send(CMD_CORE, 16'h9EA6, 0);
    prog.send(CMD_LOAD_INC, 16'h1234, 0);
    rd(ADDR_STATUS, d, r);
    check(d, 32'h0000_0010);
    wr(ADDR_STATUS, 32'h0000_0010, r);
    wr(ADDR_CTRL, 32'h0, r);
    prog.send(CMD_CORE, 16'h8EA6, 0);
    rd(ADDR_MEMCTL, d, r);
    check(d, 32'h0);
    rd(ADDR_STATUS, d, r);
    check(d, 32'h0);
    rd(ADDR_PTR, d, r);
    check(d, 32'h0000_0012);
    wr(8'h24, 32'h0, r);
    check(32'(r), 32'(RESP_SLVERR));
    tally_and_finish;
  end
  initial begin
    #160000;
    num_errors++;
    tally_and_finish;
  end
endmodule
